// ===== design/sbs_pkg.sv
package sbs_pkg;

    localparam int ADDR_W = 19;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam logic [1:0] CNT_STEP = 2'h1;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    typedef enum logic [1:0]
    {
        SBS_IDLE = 2'b00,
        SBS_READ = 2'b01,
        SBS_WRITE = 2'b10,
        SBS_SLEEP = 2'b11
    } sbs_mode_e;

    // Synchronous bus controls, all sampled at the rising edge
    typedef struct packed
    {
        logic chip_select_n;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_gate_n;
        logic [LANES-1:0] byte_lane_select_n;
    } sbs_ctrl_s;

    // Data lanes: eight data bits plus one parity bit per lane
    typedef struct packed
    {
        logic [LANES-1:0][LANE_W-1:0] data;
        logic [LANES-1:0] parity;
    } sbs_word_s;

endpackage

// ===== design/sbs_port.sv
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Controller strobe low at the edge captures the address.
// - Any address capture loads the two low address bits as burst start and clears the burst counter.
// - Both strobes low with chip select low: only the processor strobe is acted on.
// - Sleep high puts the port idle; memory contents are kept.
// - Sleep must be low for normal use; floating reads as low.
// - Write data is captured from the data lines at the rising edge.
// - Read drives data of the address captured at the previous edge.
// - Data and parity driven while output enable low, floated when high.
// - Outputs float during writes, first cycle after deselect, and deselected.
// - Parity lanes behave like data, each written by its byte select.
// - Burst-order strap low gives linear burst order.
// - Burst-order strap high or open gives interleaved order.
// - Processor strobe ignored while primary chip select is high.
// - Global write low writes all lanes regardless of byte selects.
// - A byte select writes its lane only with the byte-write gate low.
// - Advance low during a burst steps the burst counter.
module sbs_port
#(
    parameter int ADDR_W = sbs_pkg::ADDR_W
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Synchronous bus
    input wire sbs_pkg::sbs_ctrl_s ctrl,
    input wire logic [ADDR_W-1:0] address,
    // Asynchronous pins
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_interleaved,
    // Data and parity pins
    input wire sbs_pkg::sbs_word_s dq_in,
    output sbs_pkg::sbs_word_s dq_out,
    output logic dq_oe_n,
    // Status
    output logic asleep
);

    localparam int LANES = sbs_pkg::LANES;
    localparam int DEPTH = 1 << ADDR_W;

    typedef struct packed
    {
        sbs_pkg::sbs_mode_e mode;
        logic selected;
        logic first_cycle;
        logic [ADDR_W-1:0] base_addr;
        logic [1:0] start_low;
        logic [1:0] burst_cnt;
        logic [1:0] low_addr;
        logic [LANES-1:0] lane_we;
        sbs_pkg::sbs_word_s wdata;
        sbs_pkg::sbs_word_s rdata;
        logic drive_n;
        logic asleep;
        logic mode_interleaved;
        logic mode_latched;
        logic [2:0] settle;
    } sbs_state_s;

    sbs_state_s state_reg;
    sbs_state_s state_next;
    sbs_pkg::sbs_word_s mem [DEPTH];

    logic sleep_sync;
    logic oe_n_sync;
    logic strap_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Asynchronous pins are synchronised before use
    sbs_sync3 u_sleep_sync
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(sleep_request),
        .level_out(sleep_sync)
    );

    sbs_sync3 u_oe_sync
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(output_enable_n),
        .level_out(oe_n_sync)
    );

    sbs_sync3 u_strap_sync
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(burst_order_interleaved),
        .level_out(strap_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic proc_strobe;
    logic ctrl_strobe;
    logic advance;
    logic wr_req;
    logic [LANES-1:0] lanes;
    logic [1:0] cnt_inc;
    logic [1:0] next_low;
    logic [ADDR_W-1:0] cur_addr;

    always_comb
    begin
        state_next = state_reg;
        // Strap is caught once after reset; it must stay static anyway
        if (!state_reg.mode_latched)
        begin
            // Synchroniser output is its reset level until it has settled
            if (state_reg.settle == sbs_pkg::STRAP_SETTLE)
            begin
                state_next.mode_interleaved = strap_sync;
                state_next.mode_latched = 1'b1;
            end
            else
            begin
                state_next.settle = state_reg.settle + 3'h1;
            end
        end
        proc_strobe = !ctrl.processor_addr_strobe_n && !ctrl.chip_select_n;
        ctrl_strobe = !ctrl.controller_addr_strobe_n && !proc_strobe;
        advance = !ctrl.burst_advance_n && state_reg.selected;
        // Processor strobe cycles are always reads; write follows later
        wr_req = !ctrl.global_write_n
            || (!ctrl.byte_write_gate_n && (ctrl.byte_lane_select_n != '1));
        if (!ctrl.global_write_n)
        begin
            lanes = '1;
        end
        else if (!ctrl.byte_write_gate_n)
        begin
            lanes = ~ctrl.byte_lane_select_n;
        end
        else
        begin
            lanes = '0;
        end
        cnt_inc = state_reg.burst_cnt + sbs_pkg::CNT_STEP;
        if (state_reg.mode_interleaved)
        begin
            next_low = state_reg.start_low ^ cnt_inc;
        end
        else
        begin
            next_low = state_reg.low_addr + sbs_pkg::CNT_STEP;
        end
        state_next.lane_we = '0;
        state_next.first_cycle = 1'b0;
        state_next.asleep = sleep_sync;
        if (sleep_sync)
        begin
            state_next.mode = sbs_pkg::SBS_SLEEP;
            state_next.selected = 1'b0;
        end
        else if (proc_strobe || ctrl_strobe)
        begin
            state_next.first_cycle = !state_reg.selected;
            state_next.selected = !ctrl.chip_select_n;
            state_next.base_addr = address;
            state_next.start_low = address[1:0];
            state_next.low_addr = address[1:0];
            state_next.burst_cnt = sbs_pkg::BURST_RESET;
            if (!ctrl.chip_select_n && ctrl_strobe && wr_req)
            begin
                state_next.mode = sbs_pkg::SBS_WRITE;
                state_next.lane_we = lanes;
            end
            else
            begin
                state_next.mode = ctrl.chip_select_n ? sbs_pkg::SBS_IDLE : sbs_pkg::SBS_READ;
            end
        end
        else if (state_reg.selected)
        begin
            if (advance)
            begin
                state_next.burst_cnt = cnt_inc;
                state_next.low_addr = next_low;
            end
            if (wr_req)
            begin
                state_next.mode = sbs_pkg::SBS_WRITE;
                state_next.lane_we = lanes;
            end
            else
            begin
                state_next.mode = sbs_pkg::SBS_READ;
            end
        end
        else
        begin
            state_next.mode = sbs_pkg::SBS_IDLE;
        end
        state_next.wdata = dq_in;
        cur_addr = {state_next.base_addr[ADDR_W-1:2], state_next.low_addr};
        state_next.rdata = mem[cur_addr];
        state_next.drive_n = oe_n_sync
            || (state_next.mode != sbs_pkg::SBS_READ)
            || state_next.first_cycle;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array write uses the address and lanes latched with the data
    logic [ADDR_W-1:0] wr_addr;
    assign wr_addr = {state_reg.base_addr[ADDR_W-1:2], state_reg.low_addr};

    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (state_reg.lane_we[i])
            begin
                mem[wr_addr].data[i] <= state_reg.wdata.data[i];
                mem[wr_addr].parity[i] <= state_reg.wdata.parity[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '{mode: sbs_pkg::SBS_IDLE, drive_n: 1'b1, default: '0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign dq_out = state_reg.rdata;
    assign dq_oe_n = state_reg.drive_n;
    assign asleep = state_reg.asleep;

endmodule // sbs_port

// ===== design/sbs_sync3.sv
// Three-stage synchroniser; value changes once stages two and three agree
module sbs_sync3
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Asynchronous level in, settled level out
    input wire logic async_in,
    output logic level_out
);

    typedef struct packed
    {
        logic [2:0] stage;
        logic level;
    } sbs_sync_s;

    sbs_sync_s state_reg;
    sbs_sync_s state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.stage = {state_reg.stage[1:0], async_in};
        if (state_reg.stage[1] == state_reg.stage[2])
        begin
            state_next.level = state_reg.stage[2];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '{stage: sbs_pkg::SYNC_RESET, level: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.level;

endmodule // sbs_sync3

// ===== tb/sbs_bus_master.sv
module sbs_bus_master
(
    // Clock
    input wire logic sys_clk,
    // Master side
    input wire logic drive,
    input wire sbs_pkg::sbs_word_s wdata,
    // Device side
    input wire sbs_pkg::sbs_word_s dq_out,
    input wire logic dq_oe_n,
    output sbs_pkg::sbs_word_s pins
);
    timeunit 1ns;
    timeprecision 1ns;
    sbs_pkg::sbs_word_s last_reg = '0;
    always @(posedge sys_clk)
        last_reg <= pins;
    // Floating lanes flip, so a stale word never passes for data
    assign pins = drive ? wdata : (!dq_oe_n ? dq_out : ~last_reg);
endmodule // sbs_bus_master

// ===== tb/sbs_port_sva.sv
module sbs_port_sva
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Watched pins
    input wire sbs_pkg::sbs_ctrl_s ctrl,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic dq_oe_n,
    input wire logic asleep
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cs, ps, cas, wr_take, desel_take;
    assign cs = !ctrl.chip_select_n;
    // Deselect is only taken with a controller strobe; no strobe continues the burst
    assign desel_take = !cs && cas;
    assign ps = !ctrl.processor_addr_strobe_n;
    assign cas = !ctrl.controller_addr_strobe_n;
    // Selected processor strobe wins, so that cycle is never a write
    assign wr_take = cas && !(ps && cs) && (!ctrl.global_write_n
        || (!ctrl.byte_write_gate_n && ctrl.byte_lane_select_n != 4'hF));
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Eight edges cover synchroniser latency on enable and sleep
    sequence quiet;
        (!output_enable_n && !sleep_request && cs && !asleep) [*8];
    endsequence
    a_oe_float: assert property (output_enable_n [*8] |-> dq_oe_n)
        else $error("driven with output enable high");
    a_write_float: assert property (wr_take |=> dq_oe_n)
        else $error("driven in write data phase");
    a_desel_float: assert property (desel_take |=> dq_oe_n)
        else $error("driven while deselected");
    a_first_float: assert property ($past(desel_take) && cs && (ps || cas) |=> dq_oe_n)
        else $error("driven in first cycle after deselect");
    a_sleep_idle: assert property (sleep_request [*8] |-> asleep && dq_oe_n)
        else $error("not asleep");
    a_sleep_wake: assert property (!sleep_request [*8] |-> !asleep)
        else $error("asleep with sleep low");
    // Already driving means selected, so the first-cycle float does not apply
    a_read_drive: assert property (quiet ##0 (ps && !dq_oe_n) |=> !dq_oe_n)
        else $error("read not driven");
    a_both_read: assert property (quiet ##0 (ps && cas && !dq_oe_n
        && !ctrl.global_write_n) |=> !dq_oe_n)
        else $error("both strobes not taken as read");
    c_write: cover property (wr_take);
    c_burst: cover property (ps ##1 !ctrl.burst_advance_n [*3]);
    c_sleep: cover property (sleep_request [*8]);
endmodule // sbs_port_sva

////////////////////////////////////////////////////////////////////////////////
bind sbs_port sbs_port_sva i_sva (.sys_clk(sys_clk), .reset_n(reset_n), .ctrl(ctrl),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .dq_oe_n(dq_oe_n),
    .asleep(asleep));

// ===== tb/tb_sync_burst_sram_port.sv
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module tb_sync_burst_sram_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = sbs_pkg::ADDR_W;
    localparam sbs_pkg::sbs_ctrl_s IDLE = 10'h1FF;
    localparam sbs_pkg::sbs_ctrl_s BURST_ADVANCE_N = 10'h1BF;
    // Controller strobe with chip select high; the processor strobe is ignored
    localparam sbs_pkg::sbs_ctrl_s DESEL = 10'h27F;
    // Strap only changes while reset is held
    logic strap = 1'b1;
    logic sys_clk = 0, reset_n = 0, output_enable_n = 0, sleep_request = 0, mst_drive = 0;
    logic dq_oe_n, asleep;
    logic [AW-1:0] address = '0, base;
    sbs_pkg::sbs_ctrl_s ctrl = DESEL;
    sbs_pkg::sbs_word_s mst_data = '0, dq_in, dq_out, e;
    sbs_pkg::sbs_word_s mem [int];
    sbs_pkg::sbs_word_s exp_q [$];
    int due_q [$];
    int cyc = 0, mismatches = 0, n_checks = 0, seed = 54240;

    always #5 sys_clk = ~sys_clk;

    sbs_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ctrl(ctrl), .address(address),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .burst_order_interleaved(strap),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .asleep(asleep));
    sbs_bus_master i_master (.sys_clk(sys_clk), .drive(mst_drive), .wdata(mst_data),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .pins(dq_in));

////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic sbs_pkg::sbs_word_s rnd();
        rnd.data = $random(seed);
        rnd.parity = 4'($random(seed));
    endfunction

    task automatic drive(input sbs_pkg::sbs_ctrl_s c, input logic [AW-1:0] a, input logic md,
        input sbs_pkg::sbs_word_s w);
        @(posedge sys_clk);
        ctrl <= c;
        address <= a;
        mst_drive <= md;
        mst_data <= w;
    endtask

    // Output shows in the cycle after the taking edge
    task automatic expect_at(input sbs_pkg::sbs_word_s w);
        exp_q.push_back(w);
        due_q.push_back(cyc + 2);
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic gw, input logic [3:0] sel_n);
        sbs_pkg::sbs_ctrl_s c;
        sbs_pkg::sbs_word_s w;
        c = IDLE;
        w = rnd();
        c.controller_addr_strobe_n = 1'b0;
        c.global_write_n = gw;
        c.byte_write_gate_n = !gw;
        c.byte_lane_select_n = sel_n;
        for (int i = 0; i < 4; i++)
        begin
            if (!gw || !sel_n[i])
            begin
                mem[a].data[i] = w.data[i];
                mem[a].parity[i] = w.parity[i];
            end
        end
        drive(c, a, 1'b1, w);
        drive(IDLE, a, 1'b0, w);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic both, input logic chk);
        sbs_pkg::sbs_ctrl_s c;
        c = IDLE;
        c.processor_addr_strobe_n = 1'b0;
        c.controller_addr_strobe_n = !both;
        c.global_write_n = !both;
        drive(c, a, both, rnd());
        if (chk)
            expect_at(mem[a]);
    endtask

    always @(negedge sys_clk)
    begin
        cyc++;
        if (due_q.size() != 0 && due_q[0] == cyc)
        begin
            void'(due_q.pop_front());
            e = exp_q.pop_front();
            `CHK(dq_oe_n, 1'b0)
            `CHK(dq_out, e)
        end
    end

    initial
    begin
        #20000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        base = AW'($random(seed)) & 19'h7FFFC;
        for (int i = 0; i < 4; i++)
            wr(base + AW'(i), 1'b0, 4'hF);
        rd(base + 19'h00001, 1'b0, 1'b1);
        for (int k = 1; k < 4; k++)
        begin
            drive(BURST_ADVANCE_N, base, 1'b0, '0);
            expect_at(mem[base | AW'(1 ^ k)]);
        end
        for (int j = 0; j < 4; j++)
            wr(base + AW'(j), 1'b1, ~(4'h1 << j));
        for (int j = 0; j < 4; j++)
            rd(base + AW'(j), 1'b0, 1'b1);
        rd(base + 19'h00002, 1'b1, 1'b1);
        drive(IDLE, base, 1'b0, '0);
        rd(base + 19'h00002, 1'b0, 1'b1);
        repeat (3) drive(DESEL, base, 1'b0, '0);
        rd(base + 19'h00003, 1'b0, 1'b0);
        rd(base + 19'h00003, 1'b0, 1'b1);
        drive(IDLE, base, 1'b0, '0);
        output_enable_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        output_enable_n <= 1'b0;
        sleep_request <= 1'b1;
        repeat (12) @(posedge sys_clk);
        sleep_request <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rd(base + 19'h00001, 1'b0, 1'b0);
        rd(base + 19'h00001, 1'b0, 1'b1);
        drive(IDLE, base, 1'b0, '0);
        repeat (4) @(posedge sys_clk);
        // Second reset with the strap low selects linear order
        ctrl <= DESEL;
        strap <= 1'b0;
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(base + 19'h00001, 1'b0, 1'b0);
        rd(base + 19'h00001, 1'b0, 1'b1);
        for (int k = 1; k < 4; k++)
        begin
            drive(BURST_ADVANCE_N, base, 1'b0, '0);
            expect_at(mem[base | AW'((1 + k) % 4)]);
        end
        drive(IDLE, base, 1'b0, '0);
        repeat (4) @(posedge sys_clk);
        end_of_test();
    end
endmodule // tb_sync_burst_sram_port
